// ### rtl/interval_time_defs.svh
// constants for the interval and time-of-year counter
`ifndef INTERVAL_TIME_DEFS_SVH
`define INTERVAL_TIME_DEFS_SVH
`define TICK_W        32
`define FRAC_W        32
`define SEC_W         32
`define CLK_HZ        125000000
`define IRIG_SYNC_MIN 7
`define IRIG_ONE_MIN  4
`define IRIG_ONE_MAX  6
`define IRIG_SEC_POS  1
`define IRIG_MIN_POS  10
`define IRIG_HR_POS   20
`define IRIG_DAY_POS  30
`endif

// ### rtl/interval_time_pkg.sv
// types shared by the interval and time-of-year counter
package interval_time_pkg;
    typedef enum logic [1:0] {
        mode_period     = 2'h0,
        mode_semi       = 2'h1,
        mode_pulse      = 2'h2,
        mode_two_edge   = 2'h3
    } interval_mode_t;

    typedef struct packed {
        interval_mode_t mode;
        logic           start_fall;  // period/pulse/two-edge: start on falling edge
        logic           second_fall; // two-edge: stop on falling edge of second input
        logic           ext_timebase;
    } interval_cfg_t;

    typedef struct packed {
        logic        use_irig;       // 0: pulse per second, 1: time code
        logic        buffered;       // 0: on demand, 1: sample clock
        logic        armed;
    } stamp_cfg_t;

    typedef struct packed {
        logic [63:0] seconds;        // ieee double, seconds since start of year
    } stamp_t;
endpackage : interval_time_pkg

// ### rtl/edge_sync.sv
// two-stage synchroniser with edge detection
`timescale 1ns/1ps
module edge_sync #(
    parameter int N = 5
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // raw inputs and their edges
    input  wire logic [N-1:0] raw,
    output logic [N-1:0]      level,
    output logic [N-1:0]      rise,
    output logic [N-1:0]      fall
);
    logic [N-1:0] meta;
    logic [N-1:0] stable;

    // first flop feeds only the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta   <= '0;
            stable <= '0;
            level  <= '0;
        end else begin
            meta   <= raw;    // see RQ17
            stable <= meta;
            level  <= stable;
        end
    end

    // edge pulses from settled stages
    assign rise = stable & ~level;
    assign fall = ~stable & level;
endmodule : edge_sync

// ### rtl/interval_time_counter.sv
// interval and time-of-year counter top
// Functional notes
// RQ1: period mode counts ticks between two like-polarity edges of the input.
// RQ2: semi-period mode counts ticks between each edge and the next of either polarity.
// RQ3: pulse width mode counts ticks from the chosen edge to the opposite one.
// RQ4: two-edge mode counts ticks from an edge on input a to an edge on input b.
// RQ5: the result is the raw tick count of one interval.
// RQ6: the timebase is either the internal clock or an external tick input.
// RQ7: time of year syncs either from pulse per second or from the time code.
// RQ8: pulse per second only marks the start of a second.
// RQ9: the time code is decoded into elapsed time since start of year.
// RQ10: an active gate edge captures the current time of year.
// RQ11: captured stamps are 64-bit doubles of seconds since the year start.
// RQ12: the host picks on-demand or sample-clock buffered stamping.
// RQ13: in on-demand mode the host arms first and then each read gives current seconds.
// RQ14: in buffered mode every sample clock edge latches time into the output stream.
// RQ15: the other party supplies the sample clock for buffered stamping.
// RQ16: each interval end stores the count and restarts from zero without lost ticks; the code restarts only in period and semi-period modes.
// RQ17: all outside inputs pass a two-flop synchroniser before edge detection; read_req goes to the stamp capture unsynchronised.
`timescale 1ns/1ps
`include "interval_time_defs.svh"
module interval_time_counter
    import interval_time_pkg::*;
#(
    parameter int TICK_W = `TICK_W,
    parameter int CLK_HZ = `CLK_HZ
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // interval configuration and signals
    input  wire interval_cfg_t     icfg,
    input  wire logic              meas_a,
    input  wire logic              meas_b,
    input  wire logic              ext_tick,
    // interval result stream
    output logic [TICK_W-1:0]      result,
    output logic                   result_valid,
    // time-of-year configuration and signals
    input  wire stamp_cfg_t        scfg,
    input  wire logic              pps,
    input  wire logic              irig,
    input  wire logic              gate,
    input  wire logic              sample_clk,
    input  wire logic              read_req,
    // stamp stream
    output stamp_t                 stamp,
    output logic                   stamp_valid
);
    localparam int NS = 7;
    logic [NS-1:0] lvl, rise, fall;

    // lanes: 0 meas_a, 1 ext_tick, 2 sample_clk, 3 irig, 4 pps, 5 meas_b, 6 gate
    edge_sync #(.N(NS)) u_sync (
        .clk  (clk),
        .srst (srst),
        .raw  ({gate, meas_b, pps, irig, sample_clk, ext_tick, meas_a}),
        .level(lvl),
        .rise (rise),
        .fall (fall)
    );

    // ---- interval side ----
    logic              tick;
    logic              a_start, a_stop, b_stop, begun, active;
    logic [TICK_W-1:0] count;

    // timebase select
    assign tick = icfg.ext_timebase ? rise[1] : 1'b1; // see RQ6

    // start and stop edges per mode
    always_comb begin
        a_start = icfg.start_fall ? fall[0] : rise[0];
        a_stop  = 1'b0;
        b_stop  = icfg.second_fall ? fall[5] : rise[5];
        unique case (icfg.mode)
            mode_period:   a_stop = a_start;                                  // see RQ1
            mode_semi:     a_stop = rise[0] | fall[0];                        // see RQ2
            mode_pulse:    a_stop = icfg.start_fall ? rise[0] : fall[0];      // see RQ3
            mode_two_edge: a_stop = b_stop;                                   // see RQ4
        endcase
        if (icfg.mode == mode_semi)
            a_start = a_stop;
    end

    assign active = begun;

    // interval counting, restart at the ending edge in period and semi-period modes
    always_ff @(posedge clk) begin
        if (srst) begin
            begun        <= 1'b0;
            count        <= '0;
            result       <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            if (active && a_stop) begin
                result       <= count + (tick ? TICK_W'(1) : '0);   // see RQ5
                result_valid <= 1'b1;
                count        <= '0;                                 // see RQ16
                begun        <= (icfg.mode == mode_period || icfg.mode == mode_semi);
            end else if (!active && a_start) begin
                begun <= 1'b1;
                count <= '0;
            end else if (active && tick) begin
                count <= count + TICK_W'(1);
            end
        end
    end

    // ---- time of year ----
    logic [31:0] sub;      // ticks within the second
    logic [24:0] secs;     // whole seconds since year start
    logic [7:0]  irig_len; // width of current time-code pulse, ms
    logic [16:0] ms_div;
    logic [6:0]  bit_idx;
    logic        prev_sync;
    logic [24:0] irig_secs;
    logic [6:0]  bcd_acc [0:3];
    logic        gate_d;

    function automatic logic [63:0] to_double(input logic [24:0] s, input logic [31:0] f);
        logic [56:0] v;
        logic [10:0] e;
        int          k;
        v = {s, f};
        e = 11'h000;
        k = 0;
        for (int i = 0; i < 57; i++)
            if (v[i]) k = i;
        if (v != '0) e = 11'(1023 + k - 32);
        to_double = (v == '0) ? 64'h0 :
                    {1'b0, e, 52'((v << (56 - k)) >> 4)};
    endfunction : to_double

    // ticks within the second as a binary fraction of a second
    function automatic logic [31:0] frac_of(input logic [31:0] t);
        frac_of = 32'({t, 32'h0} / 64'(CLK_HZ));
    endfunction : frac_of

    // second counter, disciplined by pps or time code
    always_ff @(posedge clk) begin
        if (srst) begin
            sub  <= '0;
            secs <= '0;
        end else if (!scfg.use_irig && rise[4]) begin
            sub  <= '0;                       // see RQ8
            secs <= secs + 25'h1;
        end else if (scfg.use_irig && rise[3] && prev_sync && bit_idx == 7'h0) begin
            sub  <= '0;                       // see RQ9
            secs <= irig_secs;
        end else if (sub == 32'(CLK_HZ - 1)) begin
            sub  <= '0;
            secs <= secs + 25'h1;
        end else begin
            sub <= sub + 32'h1;
        end
    end

    // time-code pulse width decode in ms units
    always_ff @(posedge clk) begin
        if (srst) begin
            ms_div    <= '0;
            irig_len  <= '0;
            bit_idx   <= '0;
            prev_sync <= 1'b0;
            irig_secs <= '0;
            for (int j = 0; j < 4; j++) bcd_acc[j] <= '0;
        end else begin
            ms_div <= (ms_div == 17'(CLK_HZ / 1000 - 1)) ? '0 : ms_div + 17'h1;
            if (rise[3]) begin
                irig_len <= '0;
                ms_div   <= '0;
            end else if (lvl[3] && ms_div == '0 && irig_len != 8'hff) begin
                irig_len <= irig_len + 8'h1;
            end
            if (fall[3]) begin
                if (irig_len >= 8'(`IRIG_SYNC_MIN)) begin
                    if (prev_sync) begin
                        bit_idx <= '0;
                        irig_secs <= 25'((bcd_acc[3][3:0] + 10*bcd_acc[3][6:4]) * 86400
                                   + (bcd_acc[2][3:0] + 10*bcd_acc[2][6:4]) * 3600
                                   + (bcd_acc[1][3:0] + 10*bcd_acc[1][6:4]) * 60
                                   + (bcd_acc[0][3:0] + 10*bcd_acc[0][6:4]) + 1);
                    end
                    prev_sync <= 1'b1;
                end else begin
                    prev_sync <= 1'b0;
                    bit_idx   <= bit_idx + 7'h1;
                    if (irig_len >= 8'(`IRIG_ONE_MIN) && irig_len <= 8'(`IRIG_ONE_MAX)) begin
                        if (bit_idx < 7'(`IRIG_MIN_POS))
                            bcd_acc[0][bit_idx[2:0]] <= 1'b1;
                        else if (bit_idx < 7'(`IRIG_HR_POS))
                            bcd_acc[1][3'(bit_idx - 7'(`IRIG_MIN_POS))] <= 1'b1;
                        else if (bit_idx < 7'(`IRIG_DAY_POS))
                            bcd_acc[2][3'(bit_idx - 7'(`IRIG_HR_POS))] <= 1'b1;
                        else
                            bcd_acc[3][3'(bit_idx - 7'(`IRIG_DAY_POS))] <= 1'b1;
                    end
                end
            end
        end
    end

    // stamp capture: gate, sample clock or on-demand read
    always_ff @(posedge clk) begin
        if (srst) begin
            stamp       <= '0;
            stamp_valid <= 1'b0;
            gate_d      <= 1'b0;
        end else begin
            gate_d      <= 1'b0;
            stamp_valid <= 1'b0;
            if ((scfg.buffered && rise[2])          // see RQ14
                || (!scfg.buffered && scfg.armed && read_req)  // see RQ13
                || (scfg.armed && rise[6])) begin               // see RQ10
                stamp.seconds <= to_double(secs, frac_of(sub)); // see RQ11
                stamp_valid   <= 1'b1;                          // see RQ12
            end
        end
    end
endmodule : interval_time_counter

// ### sim/interval_time_props.sv
// checker on the interval and time-of-year counter ports
`timescale 1ns/1ps
module interval_time_props
    import interval_time_pkg::*;
#(
    parameter int TICK_W = 32
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              srst,
    // interval side
    input wire interval_cfg_t     icfg,
    input wire logic              meas_a,
    input wire logic              meas_b,
    input wire logic              ext_tick,
    input wire logic [TICK_W-1:0] result,
    input wire logic              result_valid,
    // time-of-year side
    input wire stamp_cfg_t        scfg,
    input wire logic              pps,
    input wire logic              irig,
    input wire logic              gate,
    input wire logic              sample_clk,
    input wire logic              read_req,
    input wire stamp_t            stamp,
    input wire logic              stamp_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic       a_q, b_q;
    logic [7:0] ra, fa, eb;
    // recent edges on the measured pins
    always_ff @(posedge clk) begin
        a_q <= meas_a;
        b_q <= meas_b;
        ra  <= {ra[6:0], meas_a & ~a_q};
        fa  <= {fa[6:0], a_q & ~meas_a};
        eb  <= {eb[6:0], meas_b ^ b_q};
    end
    property p_rpulse; result_valid |=> !result_valid; endproperty
    a_rpulse: assert property (p_rpulse)
        else $error("result valid too long");
    property p_spulse; stamp_valid |=> !stamp_valid; endproperty
    a_spulse: assert property (p_spulse)
        else $error("stamp valid too long");
    property p_cause; result_valid |-> |{ra, fa, eb}; endproperty
    a_cause: assert property (p_cause)
        else $error("result without input edge");
    property p_per; icfg == '0 && result_valid |-> |ra; endproperty
    a_per: assert property (p_per)
        else $error("period result without rising edge");
    property p_pw; icfg.mode == mode_pulse && !icfg.start_fall && result_valid |-> |fa;
    endproperty
    a_pw: assert property (p_pw)
        else $error("pulse result without falling edge");
    property p_two; icfg.mode == mode_two_edge && result_valid |-> |eb; endproperty
    a_two: assert property (p_two)
        else $error("separation result without second edge");
    property p_gate; scfg == 3'h1 && $rose(gate) |-> ##[2:8] stamp_valid; endproperty
    a_gate: assert property (p_gate)
        else $error("gate edge gave no stamp");
    property p_smp; scfg.buffered && $rose(sample_clk) |-> ##[2:8] stamp_valid; endproperty
    a_smp: assert property (p_smp)
        else $error("sample edge gave no stamp");
endmodule : interval_time_props

bind interval_time_counter interval_time_props #(.TICK_W(TICK_W)) u_props (
    .clk(clk), .srst(srst), .icfg(icfg), .meas_a(meas_a), .meas_b(meas_b),
    .ext_tick(ext_tick), .result(result), .result_valid(result_valid), .scfg(scfg),
    .pps(pps), .irig(irig), .gate(gate), .sample_clk(sample_clk), .read_req(read_req),
    .stamp(stamp), .stamp_valid(stamp_valid));

// ### sim/edge_source.sv
// model of the measured digital signals
`timescale 1ns/1ps
module edge_source (
    // clock
    input wire logic clk,
    // measured lines
    output logic     sig_a,
    output logic     sig_b
);
    initial begin
        sig_a = 1'b0;
        sig_b = 1'b0;
    end
    // n pulses on a, high hi cycles, low lo cycles
    task automatic run(input int hi, input int lo, input int n);
        repeat (n) begin
            @(posedge clk);
            sig_a <= 1'b1;
            repeat (hi) @(posedge clk);
            sig_a <= 1'b0;
            repeat (lo - 1) @(posedge clk);
        end
    endtask : run
    // rise on a, then rise on b d cycles later
    task automatic pair(input int d);
        @(posedge clk);
        sig_a <= 1'b1;
        repeat (d) @(posedge clk);
        sig_b <= 1'b1;
        repeat (4) @(posedge clk);
        sig_a <= 1'b0;
        sig_b <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pair
endmodule : edge_source

// ### sim/counter_time_and_timestamp_bench.sv
// self-checking bench for the interval and time-of-year counter
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module counter_time_and_timestamp_bench
    import interval_time_pkg::*;
;
    logic          clk = 1'b0;
    logic          srst = 1'b1;
    logic          gate = 1'b0;
    logic          sample_clk = 1'b0;
    logic          pps = 1'b0;
    logic          read_req = 1'b0;
    logic          meas_a, meas_b, result_valid, stamp_valid;
    interval_cfg_t icfg = '0;
    stamp_cfg_t    scfg = '0;
    logic [31:0]   result;
    stamp_t        stamp;
    int            error_cnt = 0;
    int            checked = 0;
    int            nstamp = 0;
    logic [31:0]   q[$];
    initial forever #4 clk = ~clk;
    interval_time_counter i_dut (.clk(clk), .srst(srst), .icfg(icfg), .meas_a(meas_a),
        .meas_b(meas_b), .ext_tick(1'b0), .result(result), .result_valid(result_valid),
        .scfg(scfg), .pps(pps), .irig(1'b0), .gate(gate), .sample_clk(sample_clk),
        .read_req(read_req), .stamp(stamp), .stamp_valid(stamp_valid));
    edge_source i_src (.clk(clk), .sig_a(meas_a), .sig_b(meas_b));
    // gather results and count stamps
    always @(posedge clk) begin
        if (result_valid === 1'b1) q.push_back(result);
        if (stamp_valid === 1'b1) nstamp++;
    end
    function automatic logic [31:0] last(input int k);
        return (q.size() > k) ? q[q.size() - 1 - k] : 'x;
    endfunction : last
    task automatic go(input interval_mode_t m, input logic f);
        @(posedge clk);
        icfg <= '{mode: m, start_fall: f, second_fall: 1'b0, ext_timebase: 1'b0};
        repeat (8) @(posedge clk);
        q.delete();
    endtask : go
    // strobes on gate or on the external sample clock
    task automatic strobe(input bit smp, input int n);
        repeat (n) begin
            @(posedge clk);
            if (smp) sample_clk <= 1'b1; else gate <= 1'b1;
            repeat (4) @(posedge clk);
            sample_clk <= 1'b0;
            gate <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask : strobe
    task automatic t_period();
        go(mode_period, 1'b0);
        i_src.run(5, 7, 3);
        repeat (12) @(posedge clk);
        `CHK(last(0), 32'h0000000c)
        `CHK(last(1), 32'h0000000c)
        go(mode_period, 1'b1);
        i_src.run(6, 4, 3);
        repeat (12) @(posedge clk);
        `CHK(last(0), 32'h0000000a)
        $display("t_period done");
    endtask : t_period
    task automatic t_semi_pulse();
        go(mode_semi, 1'b0);
        i_src.run(5, 7, 3);
        repeat (12) @(posedge clk);
        `CHK(last(0), 32'h00000005)
        `CHK(last(1), 32'h00000007)
        go(mode_pulse, 1'b0);
        i_src.run(5, 7, 2);
        repeat (12) @(posedge clk);
        `CHK(last(0), 32'h00000005)
        go(mode_pulse, 1'b1);
        i_src.run(5, 7, 2);
        repeat (12) @(posedge clk);
        `CHK(last(0), 32'h00000007)
        $display("t_semi_pulse done");
    endtask : t_semi_pulse
    task automatic t_two();
        go(mode_two_edge, 1'b0);
        i_src.pair(9);
        i_src.pair(9);
        `CHK(last(0), 32'h00000009)
        $display("t_two done");
    endtask : t_two
    task automatic t_stamp();
        int n0;
        @(posedge clk);
        scfg <= 3'h1;
        n0 = nstamp;
        strobe(1'b0, 2);
        `CHK(nstamp - n0, 2)
        scfg <= 3'h3;
        n0 = nstamp;
        strobe(1'b1, 3);
        `CHK(nstamp - n0, 3)
        $display("t_stamp done");
    endtask : t_stamp
    // two second marks, then one on-demand read
    task automatic t_pps();
        int n0;
        @(posedge clk);
        scfg <= 3'h1;
        repeat (2) begin
            @(posedge clk);
            pps <= 1'b1;
            repeat (4) @(posedge clk);
            pps <= 1'b0;
            repeat (6) @(posedge clk);
        end
        n0 = nstamp;
        @(posedge clk);
        read_req <= 1'b1;
        @(posedge clk);
        read_req <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(nstamp - n0, 1)
        `CHK(stamp.seconds[63:52], 12'h400)
        $display("t_pps done");
    endtask : t_pps
    task automatic stop_test();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_period();
        t_semi_pulse();
        t_two();
        t_stamp();
        t_pps();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule : counter_time_and_timestamp_bench
